// ==== include/xexec_pkg.sv ====
// Purpose: Shared constants and types of the extended instruction execute unit.
// Assumes: 8-bit data memory and 16-bit program words.
// Notes: Register indices are word offsets on the plain register port.
package xexec_pkg;
  // ****************************************
  // Register map and status bit positions
  // ****************************************
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_TP_LOW = 3'h2;
  localparam logic [2:0] REG_TP_HIGH = 3'h3;
  localparam logic [2:0] REG_TBL_HIGH = 3'h4;
  localparam int BIT_C = 0;
  localparam int BIT_AC = 1;
  localparam int BIT_Z = 2;
  localparam int BIT_OV = 3;
  localparam int BIT_SC = 4;
  localparam int BIT_CZ = 5;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [5:0] STATUS_RST = 6'h00;
  localparam logic [7:0] TP_RST = 8'h00;
  localparam logic [7:0] LAST_PAGE = 8'hFF;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  // ****************************************
  // Cycle counts
  // ****************************************
  localparam int SKIP_CYCLES = 3;
  localparam int PLAIN_CYCLES = 2;
  // ****************************************
  // Operation codes and states
  // ****************************************
  typedef enum logic [4:0] {
    OP_SUB_BORROW_TO_ACC = 5'h00, OP_SUB_BORROW_TO_MEM = 5'h01,
    OP_DEC_SKIP_ZERO = 5'h02, OP_DEC_SKIP_ZERO_ACC = 5'h03,
    OP_SET_BYTE = 5'h04, OP_SET_BIT = 5'h05,
    OP_INC_SKIP_ZERO = 5'h06, OP_INC_SKIP_ZERO_ACC = 5'h07,
    OP_SKIP_IF_BIT_SET = 5'h08, OP_SKIP_IF_NONZERO = 5'h09,
    OP_SUBTRACT_TO_ACC = 5'h0A, OP_SUBTRACT_TO_MEM = 5'h0B,
    OP_NIBBLE_EXCHANGE = 5'h0C, OP_NIBBLE_EXCHANGE_ACC = 5'h0D,
    OP_SKIP_IF_ZERO = 5'h0E, OP_SKIP_ZERO_WITH_MOVE = 5'h0F,
    OP_SKIP_IF_BIT_CLEAR = 5'h10, OP_PAGED_TABLE_READ = 5'h11,
    OP_LAST_PAGE_TABLE_READ = 5'h12, OP_INCR_PAGED_TABLE_READ = 5'h13,
    OP_INCR_LAST_PAGE_TABLE_READ = 5'h14, OP_EXCLUSIVE_OR_TO_ACC = 5'h15,
    OP_EXCLUSIVE_OR_TO_MEM = 5'h16
  } op_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_TBL = 5'h02, ST_TCAP = 5'h04, ST_DONE = 5'h08, ST_DUMMY = 5'h10
  } state_t;
endpackage

// ==== rtl/xexec_unit.sv ====
// Purpose: Executes the extended subtract, skip, set, swap, table read and XOR operations.
// Assumes: The core presents the operand byte beside the one-cycle start strobe.
// Notes: Results reach data memory in the DONE cycle; a skip adds one dummy cycle.
//
// How it works
// - Borrow subtract to accumulator: acc minus operand minus inverted carry; carry set if non-negative.
// - Borrow subtract to memory: same arithmetic, result written back to the memory byte.
// - All subtract forms update signed wrap, zero, half borrow, carry, sign and chained zero.
// - Decrement skip: byte minus one written back, skip when zero, flags kept.
// - Accumulator decrement skip: operand minus one into accumulator, memory kept, skip when zero.
// - A taken skip costs three cycles because a dummy cycle is inserted.
// - Set byte writes all ones and keeps every flag.
// - Set bit forces only the chosen bit to one, flags kept.
// - Increment skip: byte plus one written back, skip on wrap to zero, flags kept.
// - Accumulator increment skip: operand plus one into accumulator, skip when zero.
// - Skip when the chosen bit is one, else continue.
// - Nonzero test rewrites the byte unchanged and skips when it is not zero.
// - Plain subtract without borrow to either destination, carry set if non-negative.
// - Nibble exchange swaps halves; accumulator form leaves memory untouched.
// - Zero test rewrites the byte unchanged and skips when it is zero.
// - Move and skip copies the byte to the accumulator, skips when zero, flags kept.
// - Skip when the chosen bit is zero, else continue.
// - Paged table read splits the word at both pointers into memory and high latch.
// - Last page table read uses the top page and the low pointer only.
// - Incrementing paged read bumps the low pointer before the paged read.
// - Incrementing last page read bumps the low pointer before the last page read.
// - XOR to either destination updates only the zero flag.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module xexec_unit #(
  parameter int DM_AW = 8
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_START,
  input wire logic [4:0] I_OP,
  input wire logic [DM_AW-1:0] I_DM_ADDR,
  input wire logic [2:0] I_BIT,
  input wire logic [7:0] I_DM_RDATA,
  output logic O_BUSY,
  output logic O_DM_WR,
  output logic [DM_AW-1:0] O_DM_ADDR,
  output logic [7:0] O_DM_WDATA,
  output logic O_PM_RD,
  output logic [15:0] O_PM_ADDR,
  input wire logic [15:0] I_PM_RDATA,
  output logic O_SKIP,
  output logic [7:0] O_ACC,
  output logic [5:0] O_STATUS,
  input wire logic [2:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [7:0] O_REG_RDATA
);
  // ****************************************
  // Helper functions
  // ****************************************
  // Reports an all-zero byte.
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  // Reports the subtract forms that take the inverted carry as a borrow.
  function automatic logic is_borrow_op(input logic [4:0] op);
    is_borrow_op = (op == xexec_pkg::OP_SUB_BORROW_TO_ACC) ||
                   (op == xexec_pkg::OP_SUB_BORROW_TO_MEM);
  endfunction

  // ****************************************
  // State
  // ****************************************
  xexec_pkg::state_t state_ff, nxt_state;
  logic [7:0] acc_ff, nxt_acc;
  logic [5:0] stat_ff, nxt_stat;
  logic [7:0] tpl_ff, nxt_tpl;
  logic [7:0] tph_ff, nxt_tph;
  logic [7:0] table_high_latch_ff, nxt_table_high_latch;
  logic [7:0] wdata_ff, nxt_wdata;
  logic [DM_AW-1:0] addr_ff, nxt_addr;
  logic wr_ff, nxt_wr;
  logic skip_ff, nxt_skip;
  logic last_ff, nxt_last;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [8:0] diff;
  logic [4:0] half;
  logic bin;
  logic [7:0] opd;
  logic [7:0] r;

  // Subtractor shared by all subtract forms; bin is the borrow from an inverted carry.
  always_comb
  begin
    opd = I_DM_RDATA;
    bin = is_borrow_op(I_OP) ? ~stat_ff[xexec_pkg::BIT_C] : 1'b0;
    diff = {1'b0, acc_ff} - {1'b0, opd} - {8'h00, bin};
    half = {1'b0, acc_ff[3:0]} - {1'b0, opd[3:0]} - {4'h0, bin};
  end

  // Next-value logic: register port first, so an executing operation wins a clash.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_acc = acc_ff;
    nxt_stat = stat_ff;
    nxt_tpl = tpl_ff;
    nxt_tph = tph_ff;
    nxt_table_high_latch = table_high_latch_ff;
    nxt_wdata = wdata_ff;
    nxt_addr = addr_ff;
    nxt_wr = wr_ff;
    nxt_skip = skip_ff;
    nxt_last = last_ff;
    nxt_rdata = 8'h00;
    r = diff[7:0];
    if (I_REG_RD)
    begin
      case (I_REG_ADDR)
        xexec_pkg::REG_ACC: nxt_rdata = acc_ff;
        xexec_pkg::REG_STATUS: nxt_rdata = {2'b00, stat_ff};
        xexec_pkg::REG_TP_LOW: nxt_rdata = tpl_ff;
        xexec_pkg::REG_TP_HIGH: nxt_rdata = tph_ff;
        xexec_pkg::REG_TBL_HIGH: nxt_rdata = table_high_latch_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
    if (I_REG_WR)
    begin
      case (I_REG_ADDR)
        xexec_pkg::REG_ACC: nxt_acc = I_REG_WDATA;
        xexec_pkg::REG_STATUS: nxt_stat = I_REG_WDATA[5:0];
        xexec_pkg::REG_TP_LOW: nxt_tpl = I_REG_WDATA;
        xexec_pkg::REG_TP_HIGH: nxt_tph = I_REG_WDATA;
        xexec_pkg::REG_TBL_HIGH: nxt_table_high_latch = I_REG_WDATA;
        default: nxt_acc = acc_ff;
      endcase
    end
    case (state_ff)
      xexec_pkg::ST_IDLE:
      begin
        if (I_START)
        begin
          nxt_addr = I_DM_ADDR;
          nxt_wr = 1'b0;
          nxt_skip = 1'b0;
          nxt_state = xexec_pkg::ST_DONE;
          case (I_OP)
            xexec_pkg::OP_SUB_BORROW_TO_ACC, xexec_pkg::OP_SUB_BORROW_TO_MEM,
            xexec_pkg::OP_SUBTRACT_TO_ACC, xexec_pkg::OP_SUBTRACT_TO_MEM:
            begin
              r = diff[7:0];
              nxt_stat[xexec_pkg::BIT_C] = ~diff[8];
              nxt_stat[xexec_pkg::BIT_AC] = ~half[4];
              nxt_stat[xexec_pkg::BIT_Z] = is_zero(r);
              nxt_stat[xexec_pkg::BIT_OV] = (acc_ff[7] ^ opd[7]) & (r[7] ^ acc_ff[7]);
              nxt_stat[xexec_pkg::BIT_SC] = (acc_ff[7] ^ opd[7]) & (r[7] ^ acc_ff[7]) ^ r[7];
              nxt_stat[xexec_pkg::BIT_CZ] = is_borrow_op(I_OP) ?
                (is_zero(r) & stat_ff[xexec_pkg::BIT_CZ]) : is_zero(r);
              if (I_OP == xexec_pkg::OP_SUB_BORROW_TO_MEM || I_OP == xexec_pkg::OP_SUBTRACT_TO_MEM)
              begin
                nxt_wdata = r;
                nxt_wr = 1'b1;
              end
              else
                nxt_acc = r;
            end
            xexec_pkg::OP_DEC_SKIP_ZERO, xexec_pkg::OP_DEC_SKIP_ZERO_ACC:
            begin
              r = opd - 8'h01;
              nxt_skip = is_zero(r);
              nxt_wr = (I_OP == xexec_pkg::OP_DEC_SKIP_ZERO);
              nxt_wdata = r;
              if (I_OP == xexec_pkg::OP_DEC_SKIP_ZERO_ACC)
                nxt_acc = r;
            end
            xexec_pkg::OP_INC_SKIP_ZERO, xexec_pkg::OP_INC_SKIP_ZERO_ACC:
            begin
              r = opd + 8'h01;
              nxt_skip = is_zero(r);
              nxt_wr = (I_OP == xexec_pkg::OP_INC_SKIP_ZERO);
              nxt_wdata = r;
              if (I_OP == xexec_pkg::OP_INC_SKIP_ZERO_ACC)
                nxt_acc = r;
            end
            xexec_pkg::OP_SET_BYTE:
            begin
              nxt_wdata = xexec_pkg::ALL_ONES;
              nxt_wr = 1'b1;
            end
            xexec_pkg::OP_SET_BIT:
            begin
              nxt_wdata = opd | (8'h01 << I_BIT);
              nxt_wr = 1'b1;
            end
            xexec_pkg::OP_SKIP_IF_BIT_SET: nxt_skip = opd[I_BIT];
            xexec_pkg::OP_SKIP_IF_BIT_CLEAR: nxt_skip = ~opd[I_BIT];
            xexec_pkg::OP_SKIP_IF_NONZERO, xexec_pkg::OP_SKIP_IF_ZERO:
            begin
              nxt_wdata = opd;
              nxt_wr = 1'b1;
              nxt_skip = (I_OP == xexec_pkg::OP_SKIP_IF_ZERO) ? is_zero(opd) : ~is_zero(opd);
            end
            xexec_pkg::OP_SKIP_ZERO_WITH_MOVE:
            begin
              nxt_acc = opd;
              nxt_skip = is_zero(opd);
            end
            xexec_pkg::OP_NIBBLE_EXCHANGE:
            begin
              nxt_wdata = {opd[3:0], opd[7:4]};
              nxt_wr = 1'b1;
            end
            xexec_pkg::OP_NIBBLE_EXCHANGE_ACC: nxt_acc = {opd[3:0], opd[7:4]};
            xexec_pkg::OP_EXCLUSIVE_OR_TO_ACC, xexec_pkg::OP_EXCLUSIVE_OR_TO_MEM:
            begin
              r = acc_ff ^ opd;
              nxt_stat[xexec_pkg::BIT_Z] = is_zero(r);
              nxt_wdata = r;
              nxt_wr = (I_OP == xexec_pkg::OP_EXCLUSIVE_OR_TO_MEM);
              if (I_OP == xexec_pkg::OP_EXCLUSIVE_OR_TO_ACC)
                nxt_acc = r;
            end
            xexec_pkg::OP_PAGED_TABLE_READ, xexec_pkg::OP_LAST_PAGE_TABLE_READ,
            xexec_pkg::OP_INCR_PAGED_TABLE_READ, xexec_pkg::OP_INCR_LAST_PAGE_TABLE_READ:
            begin
              nxt_last = (I_OP == xexec_pkg::OP_LAST_PAGE_TABLE_READ) ||
                         (I_OP == xexec_pkg::OP_INCR_LAST_PAGE_TABLE_READ);
              if (I_OP == xexec_pkg::OP_INCR_PAGED_TABLE_READ ||
                  I_OP == xexec_pkg::OP_INCR_LAST_PAGE_TABLE_READ)
                nxt_tpl = tpl_ff + 8'h01;
              nxt_state = xexec_pkg::ST_TBL;
            end
            default: nxt_state = xexec_pkg::ST_DONE;
          endcase
        end
      end
      xexec_pkg::ST_TBL: nxt_state = xexec_pkg::ST_TCAP;
      xexec_pkg::ST_TCAP:
      begin
        nxt_wdata = I_PM_RDATA[7:0];
        nxt_table_high_latch = I_PM_RDATA[15:8];
        nxt_wr = 1'b1;
        nxt_state = xexec_pkg::ST_DONE;
      end
      xexec_pkg::ST_DONE: nxt_state = skip_ff ? xexec_pkg::ST_DUMMY : xexec_pkg::ST_IDLE;
      xexec_pkg::ST_DUMMY: nxt_state = xexec_pkg::ST_IDLE;
      default: nxt_state = xexec_pkg::ST_IDLE;
    endcase
  end

  // Registers every state element.
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state_ff <= xexec_pkg::ST_IDLE;
      acc_ff <= xexec_pkg::ACC_RST;
      stat_ff <= xexec_pkg::STATUS_RST;
      tpl_ff <= xexec_pkg::TP_RST;
      tph_ff <= xexec_pkg::TP_RST;
      table_high_latch_ff <= xexec_pkg::TP_RST;
      wdata_ff <= 8'h00;
      addr_ff <= '0;
      wr_ff <= 1'b0;
      skip_ff <= 1'b0;
      last_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      acc_ff <= nxt_acc;
      stat_ff <= nxt_stat;
      tpl_ff <= nxt_tpl;
      tph_ff <= nxt_tph;
      table_high_latch_ff <= nxt_table_high_latch;
      wdata_ff <= nxt_wdata;
      addr_ff <= nxt_addr;
      wr_ff <= nxt_wr;
      skip_ff <= nxt_skip;
      last_ff <= nxt_last;
      rdata_ff <= nxt_rdata;
    end
  end

  // Output drive; strobes decode the state, data come from flops.
  assign O_BUSY = (state_ff != xexec_pkg::ST_IDLE);
  assign O_DM_WR = (state_ff == xexec_pkg::ST_DONE) && wr_ff;
  assign O_SKIP = (state_ff == xexec_pkg::ST_DONE) && skip_ff;
  assign O_DM_ADDR = addr_ff;
  assign O_DM_WDATA = wdata_ff;
  assign O_PM_RD = (state_ff == xexec_pkg::ST_TBL);
  assign O_PM_ADDR = {last_ff ? xexec_pkg::LAST_PAGE : tph_ff, tpl_ff};
  assign O_ACC = acc_ff;
  assign O_STATUS = stat_ff;
  assign O_REG_RDATA = rdata_ff;

  // ****************************************
  // Assertions
  // ****************************************
  property p_set_byte;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (state_ff == xexec_pkg::ST_IDLE && I_START && I_OP == xexec_pkg::OP_SET_BYTE && !I_REG_WR)
    |=> O_DM_WR && O_DM_WDATA == 8'hFF && $stable(O_STATUS);
  endproperty
  a_set_byte: assert property (p_set_byte) else $error("Set byte wrong.");

  property p_skip_len;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    O_SKIP |=> (state_ff == xexec_pkg::ST_DUMMY) ##1 !O_BUSY;
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("Skip length wrong.");

  property p_sub_carry;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (state_ff == xexec_pkg::ST_IDLE && I_START && I_OP == xexec_pkg::OP_SUBTRACT_TO_ACC && !I_REG_WR)
    |=> O_STATUS[xexec_pkg::BIT_C] == ($past(acc_ff) >= $past(I_DM_RDATA));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("Subtract carry wrong.");

  property p_sbc_acc;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (state_ff == xexec_pkg::ST_IDLE && I_START && I_OP == xexec_pkg::OP_SUB_BORROW_TO_ACC)
    |=> O_ACC == 8'($past(acc_ff) - $past(I_DM_RDATA) - {7'h00, ~$past(stat_ff[0])});
  endproperty
  a_sbc_acc: assert property (p_sbc_acc) else $error("Borrow subtract wrong.");

  property p_dec_skip;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (state_ff == xexec_pkg::ST_IDLE && I_START && I_OP == xexec_pkg::OP_DEC_SKIP_ZERO)
    |=> O_DM_WR && O_SKIP == ($past(I_DM_RDATA) == 8'h01) && $stable(O_STATUS);
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("Decrement skip wrong.");

  property p_inc_acc;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (state_ff == xexec_pkg::ST_IDLE && I_START && I_OP == xexec_pkg::OP_INC_SKIP_ZERO_ACC)
    |=> !O_DM_WR && O_ACC == 8'($past(I_DM_RDATA) + 8'h01) && O_SKIP == (O_ACC == 8'h00);
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("Increment skip wrong.");

  property p_tbl_split;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    O_PM_RD |=> ##1 O_DM_WR && O_DM_WDATA == $past(I_PM_RDATA[7:0], 1);
  endproperty
  a_tbl_split: assert property (p_tbl_split) else $error("Table read split wrong.");

  property p_last_page;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (state_ff == xexec_pkg::ST_IDLE && I_START && I_OP == xexec_pkg::OP_INCR_LAST_PAGE_TABLE_READ
     && !I_REG_WR) |=> O_PM_RD && O_PM_ADDR == {8'hFF, 8'($past(tpl_ff) + 8'h01)};
  endproperty
  a_last_page: assert property (p_last_page) else $error("Last page address wrong.");

  property p_xor_zero;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (state_ff == xexec_pkg::ST_IDLE && I_START && I_OP == xexec_pkg::OP_EXCLUSIVE_OR_TO_MEM)
    |=> O_STATUS[2] == (O_DM_WDATA == 8'h00) && O_STATUS[1:0] == $past(stat_ff[1:0])
        && O_DM_WDATA == ($past(acc_ff) ^ $past(I_DM_RDATA));
  endproperty
  a_xor_zero: assert property (p_xor_zero) else $error("XOR zero flag wrong.");
endmodule

// ==== verif/testbench.sv ====
// Purpose: Runs every operation against a behavioural model of accumulator, flags and memory.
// Assumes: Program words follow the memory model's fixed address pattern.
// Notes: Each operation is tried with boundary bytes and a random byte; each try holds start for a refused restart at random.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic [4:0] op = 5'h00;
  logic [7:0] addr = 8'h00;
  logic [2:0] bsel = 3'h0;
  logic [2:0] ra = 3'h0;
  logic [7:0] rw = 8'h00;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic [7:0] dm_rd, waddr, wdata, acc_o, rdata;
  logic busy, wr, pm_rd, skip;
  logic [15:0] pm_a, pm_d;
  logic [5:0] st_o;
  int fail_count = 0;
  int n_compared = 0;
  int macc, mst, mtpl, mtph, mtblh;
  int mdm [256];
  int vals [5] = '{0, 1, 255, 128, 127};
  logic [7:0] d;
  // ****************************************
  // Clock, design and memory
  // ****************************************
  always #5 clk = ~clk;
  xexec_unit xexec_unit_inst (.I_CLK(clk), .I_SYS_RST(rst), .I_START(start), .I_OP(op),
    .I_DM_ADDR(addr), .I_BIT(bsel), .I_DM_RDATA(dm_rd), .O_BUSY(busy), .O_DM_WR(wr),
    .O_DM_ADDR(waddr), .O_DM_WDATA(wdata), .O_PM_RD(pm_rd), .O_PM_ADDR(pm_a),
    .I_PM_RDATA(pm_d), .O_SKIP(skip), .O_ACC(acc_o), .O_STATUS(st_o), .I_REG_ADDR(ra),
    .I_REG_WDATA(rw), .I_REG_WR(rwr), .I_REG_RD(rrd), .O_REG_RDATA(rdata));
  xexec_memory_model xexec_memory_model_inst (.i_clk(clk), .i_rd_addr(addr),
    .o_dm_rdata(dm_rd), .i_dm_wr(wr), .i_dm_addr(waddr), .i_dm_wdata(wdata),
    .i_pm_rd(pm_rd), .i_pm_addr(pm_a), .o_pm_rdata(pm_d));
  // ****************************************
  // Shared tasks
  // ****************************************
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task wreg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    ra <= a;
    rw <= v;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask
  task rreg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1 v = rdata;
  endtask
  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    macc = 0;
    mst = 0;
    mtpl = 0;
    mtph = 0;
    mtblh = 0;
  endtask
  // Subtract with optional borrow; all six flags follow the result.
  task sub(input int b, input bit brw, input bit tomem, input int a);
    int bi, f, r, ov, z;
    bi = brw ? 1 - (mst & 1) : 0;
    f = macc - b - bi;
    r = f & 255;
    z = (r == 0);
    ov = ((macc ^ b) & (macc ^ r) & 128) != 0;
    mst = (f >= 0) | ((((macc & 15) - (b & 15) - bi) >= 0) << 1) | (z << 2) | (ov << 3)
      | ((ov ^ (r >> 7)) << 4) | ((z && (!brw || mst[5])) << 5);
    if (tomem)
      mdm[a] = r;
    else
      macc = r;
  endtask
  // Behavioural effect of one operation; returns whether a skip is due.
  task model(input int o, input int a, input int bt, output int sk);
    int m, w;
    m = mdm[a];
    sk = 0;
    case (o)
      0, 1: sub(m, 1, o == 1, a);
      10, 11: sub(m, 0, o == 11, a);
      2:
      begin
        mdm[a] = (m + 255) & 255;
        sk = (mdm[a] == 0);
      end
      3:
      begin
        macc = (m + 255) & 255;
        sk = (macc == 0);
      end
      6:
      begin
        mdm[a] = (m + 1) & 255;
        sk = (mdm[a] == 0);
      end
      7:
      begin
        macc = (m + 1) & 255;
        sk = (macc == 0);
      end
      4: mdm[a] = 255;
      5: mdm[a] = m | (1 << bt);
      8: sk = m[bt];
      16: sk = !m[bt];
      9: sk = (m != 0);
      14: sk = (m == 0);
      15:
      begin
        macc = m;
        sk = (m == 0);
      end
      12: mdm[a] = ((m << 4) | (m >> 4)) & 255;
      13: macc = ((m << 4) | (m >> 4)) & 255;
      21, 22:
      begin
        w = macc ^ m;
        mst = (mst & 59) | ((w == 0) << 2);
        if (o == 22)
          mdm[a] = w;
        else
          macc = w;
      end
      default:
      begin
        if (o >= 19)
          mtpl = (mtpl + 1) & 255;
        w = ((o == 17 || o == 19) ? mtph : 255) * 256 + mtpl;
        w = ((((w >> 8) ^ 90) & 255) << 8) | ((w + 51) & 255);
        mdm[a] = w & 255;
        mtblh = w >> 8;
      end
    endcase
  endtask
  // One operation: preset registers and byte, start, time it, then compare.
  task run(input int o, input int a, input int bt, input int v, input int av, input int dbl);
    int n, sk, ex;
    logic s;
    macc = av;
    mst = $urandom & 63;
    mtpl = $urandom & 255;
    mtph = $urandom & 255;
    wreg(3'h0, macc[7:0]);
    wreg(3'h1, mst[7:0]);
    wreg(3'h2, mtpl[7:0]);
    wreg(3'h3, mtph[7:0]);
    @(posedge clk);
    xexec_memory_model_inst.dm[a] <= v[7:0];
    mdm[a] = v;
    op <= o[4:0];
    addr <= a[7:0];
    bsel <= bt[2:0];
    start <= 1'b1;
    model(o, a, bt, sk);
    @(posedge clk);
    if (dbl == 0)
      start <= 1'b0;
    n = 1;
    s = 1'b0;
    repeat (8)
    begin
      #1;
      if (skip === 1'b1)
        s = 1'b1;
      if (busy === 1'b0)
        break;
      @(posedge clk);
      start <= 1'b0;
      n++;
    end
    ex = (o >= 17 && o <= 20) ? 4 : (sk ? xexec_pkg::SKIP_CYCLES : xexec_pkg::PLAIN_CYCLES);
    chk("cycles", ex[7:0], n[7:0]);
    chk("skip", sk[7:0], {7'h00, s});
    chk("status", mst[7:0], {2'b00, st_o});
    chk("mem", mdm[a][7:0], xexec_memory_model_inst.dm[a]);
    rreg(3'h0, d);
    chk("acc", macc[7:0], d);
    chk("acc_port", macc[7:0], acc_o);
    rreg(3'h1, d);
    chk("status_reg", mst[7:0], d);
    rreg(3'h2, d);
    chk("tp_low", mtpl[7:0], d);
    rreg(3'h3, d);
    chk("tp_high", mtph[7:0], d);
    rreg(3'h4, d);
    chk("tbl_high", mtblh[7:0], d);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    void'($urandom(32'h24291275));
    do_reset();
    for (int o = 0; o < 23; o++)
      for (int k = 0; k < 6; k++)
        run(o, $urandom & 255, $urandom & 7, k == 5 ? $urandom & 255 : vals[k],
          k == 4 ? 127 : $urandom & 255, $urandom & 1);
    for (int a = 5; a < 8; a++)
    begin
      wreg(a[2:0], 8'hA5);
      rreg(a[2:0], d);
      chk("unmapped", 8'h00, d);
    end
    do_reset();
    rreg(3'h0, d);
    chk("acc_reset", 8'h00, d);
    chk("status_reset", 8'h00, {2'b00, st_o});
    run(17, 3, 0, 0, 0, 1);
    end_of_test();
  end
  // A hang is cut short well beyond the expected run length.
  initial
  begin
    #500000;
    fail_count++;
    end_of_test();
  end
endmodule

// ==== verif/xexec_memory_model.sv ====
// Purpose: Data memory and program memory facing the execute unit.
// Assumes: Byte reads are combinational; a program word arrives one cycle after its strobe.
// Notes: Outside its valid cycle the program word toggles, so stale data never passes.
`timescale 1ns/1ps
module xexec_memory_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_dm_rdata,
  input wire logic i_dm_wr,
  input wire logic [7:0] i_dm_addr,
  input wire logic [7:0] i_dm_wdata,
  input wire logic i_pm_rd,
  input wire logic [15:0] i_pm_addr,
  output logic [15:0] o_pm_rdata
);
  logic [7:0] dm [256];
  // Memory starts cleared and the program bus starts at a known level.
  initial
  begin
    for (int i = 0; i < 256; i++)
      dm[i] = 8'h00;
    o_pm_rdata = 16'h0000;
  end
  // The byte at the bench address is offered at once.
  assign o_dm_rdata = dm[i_rd_addr];
  // Writes land at the edge; a program word stands one cycle and is then inverted.
  always @(posedge i_clk)
  begin
    if (i_dm_wr)
      dm[i_dm_addr] <= i_dm_wdata;
    if (i_pm_rd)
      o_pm_rdata <= {i_pm_addr[15:8] ^ 8'h5A, i_pm_addr[7:0] + 8'h33};
    else
      o_pm_rdata <= ~o_pm_rdata;
  end
endmodule
